// [rsd_consts.svh]
// Register offsets, reset values and timing figures of the rail sequence delay block.
`ifndef RSD_CONSTS_SVH
`define RSD_CONSTS_SVH
`define RSD_ADDR_STEP_DELAYS 8'h20
`define RSD_ADDR_VOLT_CODE 8'h1b
`define RSD_ADDR_DOWN_MULT 8'h21
`define RSD_RST_STEP_DELAYS 8'h00
`define RSD_RST_VOLT_CODE 6'h33
`define RSD_RST_DOWN_MULT 1'b0
`define RSD_MULT_BIT 7
`define RSD_SHORT_MS 6'h02
`define RSD_LONG_MS 6'h05
`define RSD_DOWN_FACTOR 6'h0a
`define RSD_CLK_KHZ 40000
`define RSD_FIRST_STROBE 4'h1
`define RSD_LAST_STROBE 4'h9
`define RSD_LOW_SPLIT 6'h1a
`define RSD_LOW_BASE_MV 12'h384
`define RSD_LOW_STEP_MV 12'h019
`define RSD_HIGH_BASE_MV 12'h60e
`define RSD_HIGH_STEP_MV 12'h032
`endif

// [rsd_pkg.sv]
// Types shared by the rail sequence delay block.
`default_nettype none
package rsd_pkg;
   // One register access as presented by the serial interface front end.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rsd_reg_req_t;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT} rsd_state_t;
endpackage : rsd_pkg
`default_nettype wire

// [rsd_delay_timer.sv]
// Millisecond delay timer used between sequencer strobes.
`timescale 1ns/1ps
`default_nettype none
module rsd_delay_timer #(
   parameter int CYC_PER_MS = 40000
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Load request with the delay in milliseconds.
   input wire logic load_in,
   input wire logic [5:0] load_ms_in,
   // One-cycle pulse once the whole delay has elapsed.
   output logic done_out
);
   logic [15:0] presc, next_presc;
   logic [5:0] ms_left, next_ms_left;
   logic active, next_active, next_done;

   // The prescaler restarts on every load so a delay is never shortened by a stale partial millisecond.
   always_comb begin
      next_presc = presc;
      next_ms_left = ms_left;
      next_active = active;
      next_done = 1'b0;
      if (load_in) begin
         next_presc = 16'h0000;
         next_ms_left = load_ms_in;
         next_active = 1'b1;
      end else if (active) begin
         if (presc == 16'(CYC_PER_MS - 1)) begin
            next_presc = 16'h0000;
            next_ms_left = ms_left - 6'h01;
            if (ms_left == 6'h01) begin
               next_active = 1'b0;
               next_done = 1'b1;
            end
         end else begin
            next_presc = presc + 16'h0001;
         end
      end
   end

   // Timer state registers.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         presc <= 16'h0000;
         ms_left <= 6'h00;
         active <= 1'b0;
         done_out <= 1'b0;
      end else begin
         presc <= next_presc;
         ms_left <= next_ms_left;
         active <= next_active;
         done_out <= next_done;
      end
   end
endmodule : rsd_delay_timer
`default_nettype wire

// [rsd_top.sv]
// Step delay configuration, regulator voltage decode and strobe sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "rsd_consts.svh"
// Operation
// - Step delay register at subaddress 0x20, all bits zero after reset.
// - Bit 7 selects wait between strobes 8 and 9: 2 ms or 5 ms.
// - Bit 6 selects wait between strobes 7 and 8: 2 ms or 5 ms.
// - Bit 5 selects wait between strobes 6 and 7: 2 ms or 5 ms.
// - Bit 4 selects wait between strobes 5 and 6: 2 ms or 5 ms.
// - Bit 3 selects wait between strobes 4 and 5: 2 ms or 5 ms.
// - Bit 2 selects wait between strobes 3 and 4: 2 ms or 5 ms.
// - Bit 1 selects wait between strobes 2 and 3: 2 ms or 5 ms.
// - Bit 0 selects wait between strobes 1 and 2: 2 ms or 5 ms.
// - Voltage codes 1Ah to 3Fh decode 1.550 V to 3.400 V in 50 mV steps.
// - Voltage codes 0h to 19h decode from 0.900 V in 25 mV steps.
// - Six-bit voltage code at subaddress 0x1B resets to 33h.
// - Multiplier bit stretches every delay tenfold during power-down only.
module rsd_top
   import rsd_pkg::*;
#(
   parameter int CYC_PER_MS = `RSD_CLK_KHZ
) (
   // Clock and reset.
   input wire logic SYS_CLK_IN,
   input wire logic SYS_RST_IN,
   // Register access from the serial interface.
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic UNLOCK_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_ACK_OUT,
   // Sequencer control and strobes.
   input wire logic START_UP_IN,
   input wire logic START_DOWN_IN,
   output logic [3:0] STROBE_INDEX_OUT,
   output logic STROBE_PULSE_OUT,
   output logic SEQ_BUSY_OUT,
   // Regulator set point in millivolts.
   output logic [11:0] LDO_MILLIVOLTS_OUT
);
   rsd_reg_req_t req;
   logic [7:0] sequencer_step_delays, next_step_delays;
   logic [5:0] linear_regulator_voltage_code, next_volt_code;
   logic power_down_delay_multiplier, next_down_mult;
   logic armed, next_armed, prot_wr;
   logic [7:0] next_rdata;
   logic [11:0] next_mv;
   rsd_state_t state, next_state;
   logic going_down, next_going_down;
   logic [3:0] next_index;
   logic next_pulse, next_busy;
   logic tmr_load;
   logic [5:0] tmr_ms;
   logic tmr_done;

   assign req = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN, wr: REG_WR_IN, rd: REG_RD_IN};

   // Delay in milliseconds for the gap that follows a strobe; gap g uses bit g-1.
   function automatic logic [5:0] gap_ms(input logic [7:0] bits, input logic [3:0] gap, input logic stretch);
      logic [5:0] base;
      base = bits[3'(gap - 4'h1)] ? `RSD_LONG_MS : `RSD_SHORT_MS;
      return stretch ? 6'(base * `RSD_DOWN_FACTOR) : base;
   endfunction : gap_ms

   // Piecewise linear decode of the regulator code; the slope doubles above 19h.
   function automatic logic [11:0] code_to_mv(input logic [5:0] code);
      if (code < `RSD_LOW_SPLIT) begin
         return `RSD_LOW_BASE_MV + 12'(code * `RSD_LOW_STEP_MV);
      end else begin
         return `RSD_HIGH_BASE_MV + 12'((code - `RSD_LOW_SPLIT) * `RSD_HIGH_STEP_MV);
      end
   endfunction : code_to_mv

   // Register writes, unlock tracking and read data.
   // Every mapped register is protected, so one unlock arms exactly one write; an unlock in the
   // same cycle as a consuming write keeps the block armed for the following write.
   always_comb begin
      next_step_delays = sequencer_step_delays;
      next_volt_code = linear_regulator_voltage_code;
      next_down_mult = power_down_delay_multiplier;
      prot_wr = 1'b0;
      if (req.wr && armed) begin
         case (req.addr)
            `RSD_ADDR_STEP_DELAYS: begin
               next_step_delays = req.wdata;
               prot_wr = 1'b1;
            end
            `RSD_ADDR_VOLT_CODE: begin
               next_volt_code = req.wdata[5:0];
               prot_wr = 1'b1;
            end
            `RSD_ADDR_DOWN_MULT: begin
               next_down_mult = req.wdata[`RSD_MULT_BIT];
               prot_wr = 1'b1;
            end
            default: begin
               prot_wr = 1'b0;
            end
         endcase
      end
      next_armed = UNLOCK_IN ? 1'b1 : (prot_wr ? 1'b0 : armed);
      next_rdata = 8'h00;
      case (req.addr)
         `RSD_ADDR_STEP_DELAYS: next_rdata = sequencer_step_delays;
         `RSD_ADDR_VOLT_CODE: next_rdata = {2'b00, linear_regulator_voltage_code};
         `RSD_ADDR_DOWN_MULT: next_rdata = {power_down_delay_multiplier, 7'h00};
         default: next_rdata = 8'h00;
      endcase
      if (!req.rd) begin
         next_rdata = REG_RDATA_OUT;
      end
      next_mv = code_to_mv(linear_regulator_voltage_code);
   end

   // Register file state.
   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         sequencer_step_delays <= `RSD_RST_STEP_DELAYS;
         linear_regulator_voltage_code <= `RSD_RST_VOLT_CODE;
         power_down_delay_multiplier <= `RSD_RST_DOWN_MULT;
         armed <= 1'b0;
         REG_RDATA_OUT <= 8'h00;
         REG_ACK_OUT <= 1'b0;
         LDO_MILLIVOLTS_OUT <= 12'h000;
      end else begin
         sequencer_step_delays <= next_step_delays;
         linear_regulator_voltage_code <= next_volt_code;
         power_down_delay_multiplier <= next_down_mult;
         armed <= next_armed;
         REG_RDATA_OUT <= next_rdata;
         REG_ACK_OUT <= req.wr | req.rd;
         LDO_MILLIVOLTS_OUT <= next_mv;
      end
   end

   // Strobe sequencer: up runs strobes 1 to 9, down runs 9 to 1.
   // Starts are ignored while a sequence is running; power-down uses the gap below the current strobe.
   always_comb begin
      next_state = state;
      next_going_down = going_down;
      next_index = STROBE_INDEX_OUT;
      next_pulse = 1'b0;
      tmr_load = 1'b0;
      tmr_ms = 6'h00;
      case (state)
         ST_IDLE: begin
            if (START_UP_IN) begin
               next_index = `RSD_FIRST_STROBE;
               next_going_down = 1'b0;
               next_pulse = 1'b1;
               tmr_load = 1'b1;
               tmr_ms = gap_ms(sequencer_step_delays, `RSD_FIRST_STROBE, 1'b0);
               next_state = ST_WAIT;
            end else if (START_DOWN_IN) begin
               next_index = `RSD_LAST_STROBE;
               next_going_down = 1'b1;
               next_pulse = 1'b1;
               tmr_load = 1'b1;
               tmr_ms = gap_ms(sequencer_step_delays, `RSD_LAST_STROBE - 4'h1,
                               power_down_delay_multiplier);
               next_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (tmr_done) begin
               next_pulse = 1'b1;
               if (going_down) begin
                  next_index = STROBE_INDEX_OUT - 4'h1;
                  if (next_index != `RSD_FIRST_STROBE) begin
                     tmr_load = 1'b1;
                     tmr_ms = gap_ms(sequencer_step_delays, next_index - 4'h1,
                                     power_down_delay_multiplier);
                  end
               end else begin
                  next_index = STROBE_INDEX_OUT + 4'h1;
                  if (next_index != `RSD_LAST_STROBE) begin
                     tmr_load = 1'b1;
                     tmr_ms = gap_ms(sequencer_step_delays, next_index, 1'b0);
                  end
               end
               if (!tmr_load) begin
                  next_state = ST_IDLE;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      next_busy = (next_state == ST_WAIT);
   end

   // Sequencer state registers.
   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         state <= ST_IDLE;
         going_down <= 1'b0;
         STROBE_INDEX_OUT <= 4'h0;
         STROBE_PULSE_OUT <= 1'b0;
         SEQ_BUSY_OUT <= 1'b0;
      end else begin
         state <= next_state;
         going_down <= next_going_down;
         STROBE_INDEX_OUT <= next_index;
         STROBE_PULSE_OUT <= next_pulse;
         SEQ_BUSY_OUT <= next_busy;
      end
   end

   // Shared millisecond timer; every gap of both directions runs through this one counter.
   rsd_delay_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
      .clk_in(SYS_CLK_IN),
      .rst_in(SYS_RST_IN),
      .load_in(tmr_load),
      .load_ms_in(tmr_ms),
      .done_out(tmr_done)
   );

   // Checks on register behaviour, decode and strobe timing.
   reset_values_a: assert property (@(posedge SYS_CLK_IN)
      $fell(SYS_RST_IN) |-> sequencer_step_delays == 8'h00 && linear_regulator_voltage_code == 6'h33)
      else $error("Register reset values wrong");
   read_back_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      req.rd && req.addr == 8'h20 |=> REG_RDATA_OUT == $past(sequencer_step_delays) && REG_ACK_OUT)
      else $error("Step delay read back wrong");
   locked_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      req.wr && !armed |=> $stable(sequencer_step_delays) && $stable(linear_regulator_voltage_code))
      else $error("Write accepted without unlock");
   unlock_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      req.wr && armed && req.addr == 8'h20 |=> sequencer_step_delays == $past(req.wdata) ##1 1'b1)
      else $error("Unlocked write lost");
   decode_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      linear_regulator_voltage_code == 6'h19 |=> LDO_MILLIVOLTS_OUT == 12'h5f5)
      else $error("Low range decode wrong");
   decode_high_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      (linear_regulator_voltage_code == 6'h1a |=> LDO_MILLIVOLTS_OUT == 12'h60e) and
      (linear_regulator_voltage_code == 6'h3f |=> LDO_MILLIVOLTS_OUT == 12'hd48))
      else $error("High range decode wrong");
   gap_select_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      tmr_load && !next_going_down |-> tmr_ms == (sequencer_step_delays[3'(next_index - 4'h1)] ? 6'h05 : 6'h02))
      else $error("Power-up gap selection wrong");
   down_stretch_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      tmr_load && next_going_down |-> tmr_ms == (power_down_delay_multiplier ? 6'h0a : 6'h01) *
         (sequencer_step_delays[3'(next_index - 4'h2)] ? 6'h05 : 6'h02))
      else $error("Power-down stretch wrong");
   strobe_cause_a: assert property (@(posedge SYS_CLK_IN) disable iff (SYS_RST_IN)
      $rose(STROBE_PULSE_OUT) && $past(state) == ST_WAIT |-> $past(tmr_done))
      else $error("Strobe before delay elapsed");
endmodule : rsd_top
`default_nettype wire

// [rsd_host_model.sv]
// Host side model that writes and reads the block's registers.
`timescale 1ns/1ps
`default_nettype none
module rsd_host_model (
   // Clock.
   input wire logic clk_in,
   // Register requests toward the block.
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   output logic unlock_out,
   // Answer from the block.
   input wire logic [7:0] rdata_in,
   input wire logic ack_in
);
   // Idle bus at time zero.
   initial begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
      unlock_out = 1'b0;
   end

   // Each protected write consumes the unlock, so the host pulses unlock one cycle ahead of each write whose unl is set.
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, input logic unl, output logic acked);
      @(negedge clk_in);
      unlock_out = unl;
      @(negedge clk_in);
      unlock_out = 1'b0;
      addr_out = addr;
      wdata_out = data;
      wr_out = 1'b1;
      @(negedge clk_in);
      acked = ack_in;
      wr_out = 1'b0;
      // Released lines show the inverse so stale data never looks valid.
      addr_out = ~addr;
      wdata_out = ~data;
   endtask : write_reg

   // The answer is taken one cycle after the read strobe.
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic acked);
      @(negedge clk_in);
      addr_out = addr;
      rd_out = 1'b1;
      @(negedge clk_in);
      data = rdata_in;
      acked = ack_in;
      rd_out = 1'b0;
      addr_out = ~addr;
   endtask : read_reg
endmodule : rsd_host_model
`default_nettype wire

// [rsd_top_bench.sv]
// Self-checking bench for the step delay and regulator code block.
`timescale 1ns/1ps
`default_nettype none
module rsd_top_bench;
   localparam int CYC = 4;
   logic sys_clk;
   logic sys_rst;
   logic start_up;
   logic start_down;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic unlock;
   logic [7:0] reg_rdata;
   logic reg_ack;
   logic [3:0] strobe_index;
   logic strobe_pulse;
   logic seq_busy;
   logic [11:0] ldo_mv;
   int failures;
   int samples_checked;

   // Free running 40 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // Short millisecond count keeps the run brief.
   rsd_top #(.CYC_PER_MS(CYC)) u_dut (.SYS_CLK_IN(sys_clk), .SYS_RST_IN(sys_rst), .REG_ADDR_IN(reg_addr),
      .REG_WDATA_IN(reg_wdata), .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .UNLOCK_IN(unlock),
      .REG_RDATA_OUT(reg_rdata), .REG_ACK_OUT(reg_ack), .START_UP_IN(start_up), .START_DOWN_IN(start_down),
      .STROBE_INDEX_OUT(strobe_index), .STROBE_PULSE_OUT(strobe_pulse), .SEQ_BUSY_OUT(seq_busy),
      .LDO_MILLIVOLTS_OUT(ldo_mv));

   rsd_host_model u_host (.clk_in(sys_clk), .addr_out(reg_addr), .wdata_out(reg_wdata), .wr_out(reg_wr),
      .rd_out(reg_rd), .unlock_out(unlock), .rdata_in(reg_rdata), .ack_in(reg_ack));

   // Value comparison.
   task automatic check_val(input string name, input logic [11:0] exp, input logic [11:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val

   // Cycle count comparison.
   task automatic check_cnt(input string name, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", name, exp, got);
      end
   endtask : check_cnt

   // Closing report.
   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // Register write with the acknowledge checked.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic unl);
      logic acked;
      u_host.write_reg(addr, data, unl, acked);
      check_val("write ack", 12'h001, {11'h000, acked});
   endtask : wr

   // Register read compared with the expected value.
   task automatic rd(input string name, input logic [7:0] addr, input logic [7:0] exp);
      logic acked;
      logic [7:0] got;
      u_host.read_reg(addr, got, acked);
      check_val("read ack", 12'h001, {11'h000, acked});
      check_val(name, {4'h0, exp}, {4'h0, got});
   endtask : rd

   // Start a sequence and time every strobe against the selected delays.
   task automatic run_seq(input logic down, input logic [7:0] bits, input logic mult);
      int n;
      int exp_gap;
      int k;
      int ms;
      exp_gap = 0;
      repeat (2) @(negedge sys_clk);
      start_up = ~down;
      start_down = down;
      @(negedge sys_clk);
      start_up = 1'b0;
      start_down = 1'b0;
      for (int i = 0; i < 9; i++) begin
         k = down ? 9 - i : i + 1;
         n = (i == 0) ? 0 : 1;
         while (strobe_pulse !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            start_up = 1'b0;
            start_down = 1'b0;
            n++;
         end
         // A lost strobe counts once and leaves the sequence; the closing report follows at the end.
         if (n >= 300) begin
            failures++;
            return;
         end
         check_cnt("strobe gap", exp_gap, n);
         check_val("strobe index", 12'(k), {8'h00, strobe_index});
         check_val("busy", {11'h000, i != 8}, {11'h000, seq_busy});
         if (i < 8) begin
            ms = bits[down ? k - 2 : k - 1] ? 5 : 2;
            exp_gap = ms * ((down && mult) ? 10 : 1) * CYC + 1;
            @(negedge sys_clk);
            // Both starts during the first gap must be ignored, so index and timing stay unchanged.
            start_up = (i == 0);
            start_down = (i == 0);
         end
      end
   endtask : run_seq

   // Main sequence: reset values, lock, voltage decode, then timed sequences.
   initial begin
      logic [5:0] code;
      start_up = 1'b0;
      start_down = 1'b0;
      sys_rst = 1'b1;
      repeat (6) @(negedge sys_clk);
      sys_rst = 1'b0;
      rd("step delays reset", 8'h20, 8'h00);
      rd("volt code reset", 8'h1b, 8'h33);
      rd("multiplier reset", 8'h21, 8'h00);
      check_val("millivolts reset", 12'haf0, ldo_mv);
      rd("unmapped", 8'h30, 8'h00);
      wr(8'h20, 8'ha5, 1'b1);
      wr(8'h20, 8'hff, 1'b0);
      rd("locked write", 8'h20, 8'ha5);
      for (int c = 0; c < 64; c++) begin
         code = 6'(c);
         wr(8'h1b, {2'b11, code}, 1'b1);
         @(negedge sys_clk);
         check_val("millivolts", 12'(c < 26 ? 900 + 25 * c : 1550 + 50 * (c - 26)), ldo_mv);
         rd("volt code", 8'h1b, {2'b00, code});
      end
      run_seq(1'b0, 8'ha5, 1'b0);
      wr(8'h21, 8'h81, 1'b1);
      rd("multiplier", 8'h21, 8'h80);
      run_seq(1'b0, 8'ha5, 1'b1);
      run_seq(1'b1, 8'ha5, 1'b1);
      wr(8'h21, 8'h00, 1'b1);
      wr(8'h20, 8'h5a, 1'b1);
      run_seq(1'b1, 8'h5a, 1'b0);
      summarize();
   end
endmodule : rsd_top_bench
`default_nettype wire
